//--- core/cmsc_consts.vh
// constants for the core memory select control block
// assumes inclusion by bare name from the design files under core/
`ifndef CMSC_CONSTS_VH
`define CMSC_CONSTS_VH

// ****************************************
// widths
// ****************************************
`define CMSC_ADDR_W 15
`define CMSC_WORD_W 33
`define CMSC_LO_W 17
`define CMSC_HI_W 16
`define CMSC_INH_W 264

// ****************************************
// address field positions
// ****************************************
`define CMSC_YCS_LSB 2
`define CMSC_XCS_LSB 5
`define CMSC_YVS_LSB 8
`define CMSC_XVS_LSB 12
`define CMSC_HALF_BIT 16
`define CMSC_INH_B6 6
`define CMSC_SEN_B2 2
`define CMSC_SEN_B4 4

// ****************************************
// timing taps in ns at 100 ns per cycle
// ****************************************
`define CMSC_CLK_NS 100
`define CMSC_T_VS_NS 100
`define CMSC_T_YRD_NS 200
`define CMSC_T_XRD_NS 300
`define CMSC_T_STB_NS 500
`define CMSC_T_RDEND_NS 700
`define CMSC_T_INH_NS 100
`define CMSC_T_YWR_NS 200
`define CMSC_T_XWR_NS 300
`define CMSC_T_WREND_NS 600
`define CMSC_T_DONE_NS 800

// ****************************************
// reset values
// ****************************************
`define CMSC_ADDR_RST 15'h0000
`define CMSC_WORD_RST 33'h000000000

`endif

//--- core/cmsc_onehot_dec.v
// one-hot decoder used for switch, winding and emitter selects
// assumes its index input is held stable by the caller
`timescale 1ns/1ns
`default_nettype none
module cmsc_onehot_dec #(
	parameter IW = 3,
	parameter OW = 8
) (
	// index and gate
	input wire [IW-1:0] idx_i,
	input wire en_i,
	// one-hot result
	output reg [OW-1:0] sel_o
);
	integer k;

	// one bit set for the index when enabled
	always @* begin
		for (k = 0; k < OW; k = k + 1) begin
			sel_o[k] = en_i && (idx_i == k[IW-1:0]);
		end
	end
endmodule // cmsc_onehot_dec
`default_nettype wire

//--- core/cmsc_core.v
// memory bank select control: timing chain, address and word hold, selects
// assumes host commands are one-cycle pulses from logic on ref_clk_i and
// sense outputs arrive from pins, so they are synchronised here
`timescale 1ns/1ns
`default_nettype none
`include "cmsc_consts.vh"
module cmsc_core #(
	parameter FIRST_HALF_FIRST_BANK = 1'b1,
	parameter TW = 4
) (
	// clock and reset
	input wire ref_clk_i,
	input wire rst_n_i,
	// host commands
	input wire start_i,
	input wire restore_write_command_i,
	input wire global_clear_command_i,
	input wire load_word_i,
	// host address and data
	input wire [`CMSC_ADDR_W-1:0] addr_i,
	input wire [`CMSC_WORD_W-1:0] wdata_i,
	input wire extra_y_i,
	// sense amplifier outputs
	input wire [`CMSC_WORD_W-1:0] sense_i,
	// host status
	output reg [`CMSC_WORD_W-1:0] rdata_o,
	output reg busy_o,
	output reg locked_o,
	output reg done_o,
	// drive selects
	output reg [15:0] x_vs_o,
	output reg [16:0] y_vs_o,
	output reg [7:0] x_rd_cs_o,
	output reg [7:0] y_rd_cs_o,
	output reg [7:0] x_wr_cs_o,
	output reg [7:0] y_wr_cs_o,
	output reg [1:0] half_o,
	// inhibit and sense selects
	output reg [`CMSC_INH_W-1:0] inh_o,
	output reg [3:0] sense_pair_o,
	output reg sense_strobe_o
);
	// ****************************************
	// tap counts derived from ns figures
	// ****************************************
	// whole-cycle counts first, then cut to the counter width on purpose
	localparam integer N_VS = `CMSC_T_VS_NS / `CMSC_CLK_NS;
	localparam integer N_YRD = `CMSC_T_YRD_NS / `CMSC_CLK_NS;
	localparam integer N_XRD = `CMSC_T_XRD_NS / `CMSC_CLK_NS;
	localparam integer N_STB = `CMSC_T_STB_NS / `CMSC_CLK_NS;
	localparam integer N_RDEND = `CMSC_T_RDEND_NS / `CMSC_CLK_NS;
	localparam integer N_INH = `CMSC_T_INH_NS / `CMSC_CLK_NS;
	localparam integer N_YWR = `CMSC_T_YWR_NS / `CMSC_CLK_NS;
	localparam integer N_XWR = `CMSC_T_XWR_NS / `CMSC_CLK_NS;
	localparam integer N_WREND = `CMSC_T_WREND_NS / `CMSC_CLK_NS;
	localparam integer N_DONE = `CMSC_T_DONE_NS / `CMSC_CLK_NS;
	// TW must hold the largest tap, or the chain wraps early
	localparam [TW-1:0] T_VS = N_VS[TW-1:0];
	localparam [TW-1:0] T_YRD = N_YRD[TW-1:0];
	localparam [TW-1:0] T_XRD = N_XRD[TW-1:0];
	localparam [TW-1:0] T_STB = N_STB[TW-1:0];
	localparam [TW-1:0] T_RDEND = N_RDEND[TW-1:0];
	localparam [TW-1:0] T_INH = N_INH[TW-1:0];
	localparam [TW-1:0] T_YWR = N_YWR[TW-1:0];
	localparam [TW-1:0] T_XWR = N_XWR[TW-1:0];
	localparam [TW-1:0] T_WREND = N_WREND[TW-1:0];
	localparam [TW-1:0] T_DONE = N_DONE[TW-1:0];

	// ****************************************
	// states
	// ****************************************
	localparam [2:0] S_IDLE = 3'h0;
	localparam [2:0] S_READ = 3'h1;
	localparam [2:0] S_LOCK = 3'h2;
	localparam [2:0] S_WRITE = 3'h3;

	reg [2:0] state_r;
	reg [TW-1:0] cnt_r;
	reg [`CMSC_ADDR_W-1:0] address_hold_register_r;
	reg [`CMSC_WORD_W-1:0] word_hold_register_r;
	reg extra_y_r;
	reg rw_pending_r;
	reg [`CMSC_WORD_W-1:0] sns_a_r;
	reg [`CMSC_WORD_W-1:0] sns_b_r;
	reg [`CMSC_WORD_W-1:0] sns_c_r;
	wire [`CMSC_WORD_W-1:0] sns_hit;
	wire [7:0] ycs_dec;
	wire [7:0] xcs_dec;
	wire [15:0] yvs_dec;
	wire [15:0] xvs_dec;
	wire [7:0] emit_dec;
	wire [3:0] sen_dec;
	wire rd_phase;
	wire wr_phase;
	wire in_cycle;
	wire yrd_on;
	wire xrd_on;
	wire ywr_on;
	wire xwr_on;
	wire inh_lo_clk;
	wire inh_hi_clk;
	wire stb_on;
	integer b;
	integer e;

	// ****************************************
	// sense input synchroniser
	// ****************************************
	// three stages; a bit counts only where second and third agree
	always @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			sns_a_r <= `CMSC_WORD_RST;
			sns_b_r <= `CMSC_WORD_RST;
			sns_c_r <= `CMSC_WORD_RST;
		end else begin
			sns_a_r <= sense_i;
			sns_b_r <= sns_a_r;
			sns_c_r <= sns_b_r;
		end
	end
	assign sns_hit = sns_b_r & sns_c_r;

	// ****************************************
	// timing taps
	// ****************************************
	// each pulse is a window of the cycle counter
	assign rd_phase = (state_r == S_READ);
	assign wr_phase = (state_r == S_WRITE);
	assign in_cycle = rd_phase || wr_phase || (state_r == S_LOCK);
	assign yrd_on = rd_phase && cnt_r >= T_YRD && cnt_r < T_RDEND;
	assign xrd_on = rd_phase && cnt_r >= T_XRD && cnt_r < T_RDEND;
	assign stb_on = rd_phase && cnt_r == T_STB;
	assign inh_lo_clk = wr_phase && cnt_r >= T_INH && cnt_r < T_DONE;
	assign inh_hi_clk = wr_phase && cnt_r >= T_INH && cnt_r < T_DONE;
	assign ywr_on = wr_phase && cnt_r >= T_YWR && cnt_r < T_WREND;
	assign xwr_on = wr_phase && cnt_r >= T_XWR && cnt_r < T_WREND;

	// ****************************************
	// cycle control
	// ****************************************
	// clear wins over every command; lock ignores all but load-word and restore-write
	always @(posedge ref_clk_i) begin
		if (!rst_n_i || global_clear_command_i) begin
			state_r <= S_IDLE;
			cnt_r <= {TW{1'b0}};
			rw_pending_r <= 1'b0;
			address_hold_register_r <= `CMSC_ADDR_RST;
			word_hold_register_r <= `CMSC_WORD_RST;
			extra_y_r <= 1'b0;
		end else begin
			case (state_r)
			S_IDLE: begin
				if (start_i) begin
					state_r <= S_READ;
					cnt_r <= {TW{1'b0}};
					address_hold_register_r <= addr_i;
					extra_y_r <= extra_y_i & FIRST_HALF_FIRST_BANK;
					rw_pending_r <= restore_write_command_i;
					word_hold_register_r <= `CMSC_WORD_RST;
				end else if (load_word_i) begin
					word_hold_register_r <= wdata_i;
				end
			end
			S_READ: begin
				cnt_r <= cnt_r + 1'b1;
				if (restore_write_command_i)
					rw_pending_r <= 1'b1;
				if (stb_on)
					word_hold_register_r <= word_hold_register_r | sns_hit;
				if (cnt_r == T_RDEND) begin
					cnt_r <= {TW{1'b0}};
					state_r <= (rw_pending_r || restore_write_command_i) ?
						S_WRITE : S_LOCK;
				end
			end
			S_LOCK: begin
				// split cycle: host may replace data before restoring
				if (load_word_i)
					word_hold_register_r <= wdata_i;
				if (restore_write_command_i) begin
					state_r <= S_WRITE;
					cnt_r <= {TW{1'b0}};
				end
			end
			S_WRITE: begin
				// sense activity here never touches the word register
				cnt_r <= cnt_r + 1'b1;
				if (cnt_r == T_DONE) begin
					state_r <= S_IDLE;
					cnt_r <= {TW{1'b0}};
					rw_pending_r <= 1'b0;
				end
			end
			default: begin
				state_r <= S_IDLE;
				cnt_r <= {TW{1'b0}};
			end
			endcase
		end
	end

	// ****************************************
	// decoders from the one held address
	// ****************************************
	// one register pair serves both halves; no per-half copies
	cmsc_onehot_dec #(.IW(3), .OW(8)) u_ycs (
		.idx_i(address_hold_register_r[`CMSC_YCS_LSB+:3]),
		.en_i(1'b1),
		.sel_o(ycs_dec)
	);
	cmsc_onehot_dec #(.IW(3), .OW(8)) u_xcs (
		.idx_i(address_hold_register_r[`CMSC_XCS_LSB+:3]),
		.en_i(1'b1),
		.sel_o(xcs_dec)
	);
	cmsc_onehot_dec #(.IW(4), .OW(16)) u_yvs (
		.idx_i(address_hold_register_r[`CMSC_YVS_LSB+:4]),
		.en_i(!extra_y_r),
		.sel_o(yvs_dec)
	);
	cmsc_onehot_dec #(.IW(4), .OW(16)) u_xvs (
		.idx_i({1'b0, address_hold_register_r[`CMSC_XVS_LSB+:3]} |
			{address_hold_register_r[14], 3'h0}),
		.en_i(1'b1),
		.sel_o(xvs_dec)
	);
	// bits 14, 13 and 6 choose the inhibit emitter line
	cmsc_onehot_dec #(.IW(3), .OW(8)) u_emit (
		.idx_i({address_hold_register_r[14], address_hold_register_r[13],
			address_hold_register_r[`CMSC_INH_B6]}),
		.en_i(1'b1),
		.sel_o(emit_dec)
	);
	cmsc_onehot_dec #(.IW(2), .OW(4)) u_sen (
		.idx_i({address_hold_register_r[`CMSC_SEN_B4],
			address_hold_register_r[`CMSC_SEN_B2]}),
		.en_i(1'b1),
		.sel_o(sen_dec)
	);

	// ****************************************
	// registered select outputs
	// ****************************************
	// voltage selects from the first tap, current selects strictly later
	always @(posedge ref_clk_i) begin
		if (!rst_n_i || global_clear_command_i) begin
			x_vs_o <= 16'h0000;
			y_vs_o <= 17'h00000;
			x_rd_cs_o <= 8'h00;
			y_rd_cs_o <= 8'h00;
			x_wr_cs_o <= 8'h00;
			y_wr_cs_o <= 8'h00;
			half_o <= 2'h0;
			inh_o <= {`CMSC_INH_W{1'b0}};
			sense_pair_o <= 4'h0;
			sense_strobe_o <= 1'b0;
		end else begin
			if (in_cycle && (cnt_r >= T_VS || !rd_phase)) begin
				x_vs_o <= xvs_dec;
				// extra select forms the non-addressable region
				y_vs_o <= {extra_y_r, yvs_dec};
				half_o <= address_hold_register_r[`CMSC_ADDR_W-1] ?
					2'h2 : 2'h1;
				sense_pair_o <= sen_dec;
			end else begin
				x_vs_o <= 16'h0000;
				y_vs_o <= 17'h00000;
				half_o <= 2'h0;
				sense_pair_o <= 4'h0;
			end
			y_rd_cs_o <= yrd_on ? ycs_dec : 8'h00;
			x_rd_cs_o <= xrd_on ? xcs_dec : 8'h00;
			y_wr_cs_o <= ywr_on ? ycs_dec : 8'h00;
			x_wr_cs_o <= xwr_on ? xcs_dec : 8'h00;
			sense_strobe_o <= stb_on;
			// low half-word matrix then high half-word matrix
			for (b = 0; b < `CMSC_WORD_W; b = b + 1) begin
				for (e = 0; e < 8; e = e + 1) begin
					inh_o[b*8+e] <= !word_hold_register_r[b] &&
						emit_dec[e] &&
						((b < `CMSC_LO_W) ? inh_lo_clk : inh_hi_clk);
				end
			end
		end
	end

	// ****************************************
	// host status
	// ****************************************
	always @(posedge ref_clk_i) begin
		if (!rst_n_i || global_clear_command_i) begin
			rdata_o <= `CMSC_WORD_RST;
			busy_o <= 1'b0;
			locked_o <= 1'b0;
			done_o <= 1'b0;
		end else begin
			rdata_o <= word_hold_register_r;
			busy_o <= in_cycle;
			locked_o <= (state_r == S_LOCK);
			done_o <= wr_phase && (cnt_r == T_DONE);
		end
	end
endmodule // cmsc_core
`default_nettype wire

//--- testbench/cmsc_core_assertions.sv
// port checker for the memory select control block
// assumes one clock domain and a bind onto every cmsc_core
`timescale 1ns/1ns
`default_nettype none
module cmsc_core_assertions (
	// clock, reset and host side
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic start_i,
	input wire logic restore_write_command_i,
	input wire logic global_clear_command_i,
	input wire logic [14:0] addr_i,
	input wire logic extra_y_i,
	// design outputs
	input wire logic [32:0] rdata_o,
	input wire logic busy_o,
	input wire logic locked_o,
	input wire logic [15:0] x_vs_o,
	input wire logic [16:0] y_vs_o,
	input wire logic [7:0] x_rd_cs_o,
	input wire logic [7:0] y_rd_cs_o,
	input wire logic [7:0] x_wr_cs_o,
	input wire logic [7:0] y_wr_cs_o,
	input wire logic [1:0] half_o,
	input wire logic [3:0] sense_pair_o,
	input wire logic sense_strobe_o
);
	// ****************************************
	// held address copy and properties
	// ****************************************
	logic [14:0] addr_r;
	logic ey_r;
	// decode is judged against the address taken with start
	always @(posedge ref_clk_i) begin
		if (start_i && !busy_o && !global_clear_command_i) begin
			addr_r <= addr_i;
			ey_r <= extra_y_i;
		end
	end
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_n_i);
	sequence s_vs_was_on;
		$past(|y_vs_o);
	endsequence
	sequence s_ycs_was_on;
		$past(|y_rd_cs_o);
	endsequence
	sequence s_ywr_was_on;
		$past(|y_wr_cs_o);
	endsequence
	// busy is a registered copy of the state, so it shows two edges late
	property p_start;
		start_i && !busy_o && !global_clear_command_i |-> ##2 busy_o;
	endproperty
	a_start: assert property (p_start) else $error("start not taken");
	property p_cause;
		$rose(busy_o) |-> $past(start_i, 2);
	endproperty
	a_cause: assert property (p_cause) else $error("busy w/o start");
	property p_vs_first;
		$rose(|y_rd_cs_o) |-> s_vs_was_on;
	endproperty
	a_vs_first: assert property (p_vs_first) else $error("cs before vs");
	property p_y_then_x;
		$rose(|x_rd_cs_o) |-> s_ycs_was_on;
	endproperty
	a_y_then_x: assert property (p_y_then_x) else $error("x before y");
	property p_ycs;
		|y_rd_cs_o |-> y_rd_cs_o == 8'h01 << addr_r[4:2];
	endproperty
	a_ycs: assert property (p_ycs) else $error("y cs decode");
	property p_xcs;
		|x_rd_cs_o |-> x_rd_cs_o == 8'h01 << addr_r[7:5];
	endproperty
	a_xcs: assert property (p_xcs) else $error("x cs decode");
	// the extra select replaces the normal one for the hidden region
	property p_yvs;
		|y_vs_o |-> y_vs_o ==
			(ey_r ? 17'h10000 : 17'h00001 << addr_r[11:8]);
	endproperty
	a_yvs: assert property (p_yvs) else $error("y vs decode");
	property p_xvs;
		$onehot0(x_vs_o) and (|x_rd_cs_o |-> |x_vs_o);
	endproperty
	a_xvs: assert property (p_xvs) else $error("x vs select");
	property p_half;
		|half_o |-> half_o == (addr_r[14] ? 2'b10 : 2'b01);
	endproperty
	a_half: assert property (p_half) else $error("half select");
	property p_pair;
		|sense_pair_o |-> sense_pair_o == 4'h1 << {addr_r[4], addr_r[2]};
	endproperty
	a_pair: assert property (p_pair) else $error("sense pair");
	property p_lock;
		locked_o && !restore_write_command_i && !global_clear_command_i &&
			!$past(restore_write_command_i) |=> locked_o;
	endproperty
	a_lock: assert property (p_lock) else $error("lock left");
	property p_strobe;
		sense_strobe_o |-> |x_rd_cs_o && !(|y_wr_cs_o) ##1 !sense_strobe_o;
	endproperty
	a_strobe: assert property (p_strobe) else $error("strobe");
	property p_clear;
		global_clear_command_i |=> !busy_o && !locked_o ##1 rdata_o == 33'h0;
	endproperty
	a_clear: assert property (p_clear) else $error("clear");
	property p_x_wr;
		$rose(|x_wr_cs_o) |-> s_ywr_was_on;
	endproperty
	a_x_wr: assert property (p_x_wr) else $error("x write early");
endmodule // cmsc_core_assertions
bind cmsc_core cmsc_core_assertions u_chk (
	.ref_clk_i(ref_clk_i),
	.rst_n_i(rst_n_i),
	.start_i(start_i),
	.restore_write_command_i(restore_write_command_i),
	.global_clear_command_i(global_clear_command_i),
	.addr_i(addr_i),
	.extra_y_i(extra_y_i),
	.rdata_o(rdata_o),
	.busy_o(busy_o),
	.locked_o(locked_o),
	.x_vs_o(x_vs_o),
	.y_vs_o(y_vs_o),
	.x_rd_cs_o(x_rd_cs_o),
	.y_rd_cs_o(y_rd_cs_o),
	.x_wr_cs_o(x_wr_cs_o),
	.y_wr_cs_o(y_wr_cs_o),
	.half_o(half_o),
	.sense_pair_o(sense_pair_o),
	.sense_strobe_o(sense_strobe_o)
);
`default_nettype wire

//--- testbench/cmsc_host_model.sv
// host processor model issuing one-cycle memory commands
// assumes the caller waits for the memory's status between commands
`timescale 1ns/1ns
`default_nettype none
module cmsc_host_model (
	// clock
	input wire logic ref_clk_i,
	// commands and data towards the memory
	output logic start_o,
	output logic restore_o,
	output logic clear_o,
	output logic load_o,
	output logic [14:0] addr_o,
	output logic [32:0] wdata_o
);
	// ****************************************
	// command issue
	// ****************************************
	initial begin
		{start_o, restore_o, clear_o, load_o} = 4'h0;
		addr_o = 15'h0000;
		wdata_o = 33'h000000000;
	end
	// one pulse; data bus shows junk once released
	task automatic cmd(input logic [14:0] a, input logic s, r, c, l,
			input logic [32:0] d);
		@(posedge ref_clk_i);
		start_o <= s;
		restore_o <= r;
		clear_o <= c;
		load_o <= l;
		addr_o <= a;
		wdata_o <= d;
		@(posedge ref_clk_i);
		{start_o, restore_o, clear_o, load_o} <= 4'h0;
		wdata_o <= ~d;
	endtask
endmodule // cmsc_host_model
`default_nettype wire

//--- testbench/core_memory_select_control_tb_top.sv
// self-checking bench for the memory select control block
// assumes cmsc_core and the host model compile before it
`timescale 1ns/1ns
`default_nettype none
module core_memory_select_control_tb_top;
	// ****************************************
	// nets, host, design
	// ****************************************
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic ey = 1'b0;
	logic st, rw, clr, ld, busy, locked, done, strobe, lk_q;
	logic [14:0] addr, a;
	logic [32:0] wdata, rdata, w, s;
	logic [32:0] sense = 33'h0;
	logic [15:0] xvs;
	logic [16:0] yvs;
	logic [7:0] xrd, yrd, xwr, ywr;
	logic [1:0] half;
	logic [263:0] inh, e_inh;
	logic [3:0] pair;
	logic [32:0] expq[$];
	integer seed, mismatches = 0, comparisons = 0, cyc = 0;
	cmsc_host_model host (.ref_clk_i(clk), .start_o(st), .restore_o(rw),
		.clear_o(clr), .load_o(ld), .addr_o(addr), .wdata_o(wdata));
	cmsc_core uut (.ref_clk_i(clk), .rst_n_i(rst_n), .start_i(st),
		.restore_write_command_i(rw), .global_clear_command_i(clr),
		.load_word_i(ld), .addr_i(addr), .wdata_i(wdata), .extra_y_i(ey),
		.sense_i(sense), .rdata_o(rdata), .busy_o(busy), .locked_o(locked),
		.done_o(done), .x_vs_o(xvs), .y_vs_o(yvs), .x_rd_cs_o(xrd),
		.y_rd_cs_o(yrd), .x_wr_cs_o(xwr), .y_wr_cs_o(ywr), .half_o(half),
		.inh_o(inh), .sense_pair_o(pair), .sense_strobe_o(strobe));
	always #50 clk = ~clk;
	// ****************************************
	// helpers
	// ****************************************
	task automatic check(input string nm, input logic [263:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic finish_test;
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// sample one step after the edge so design updates have landed
	task automatic tick;
		@(posedge clk);
		#1;
	endtask
	// bounded wait: 0 done, 1 locked, 2 inhibit active
	task automatic wait_on(input int sel);
		int n;
		n = 0;
		while (n < 40 && !(sel == 0 ? done === 1'b1 : sel == 1 ?
				locked === 1'b1 : |inh === 1'b1)) begin
			tick();
			n++;
		end
		check("wait", n < 40, 1'b1);
	endtask
	// monitor: read word reaches the host once the read phase ends
	always @(posedge clk) begin
		lk_q <= locked;
		if (locked === 1'b1 && lk_q !== 1'b1 && expq.size() > 0)
			check("rdata_lock", rdata, expq.pop_front());
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			mismatches++;
			finish_test();
		end
	end
	// ****************************************
	// scenarios
	// ****************************************
	initial begin
		seed = 32'hd9df1129;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		// full cycles, restore given with start, random addresses
		repeat (6) begin
			host.cmd(15'($random(seed)), 1'b1, 1'b1, 1'b0, 1'b0, 33'h0);
			wait_on(0);
		end
		// extra Y select of the first half-bank
		@(posedge clk);
		ey <= 1'b1;
		host.cmd(15'($random(seed)), 1'b1, 1'b1, 1'b0, 1'b0, 33'h0);
		repeat (3) tick();
		check("yvs_extra", yvs, 17'h10000);
		@(posedge clk);
		ey <= 1'b0;
		wait_on(0);
		// read without restore, sense stable well before the strobe
		s = 33'({$random(seed), $random(seed)});
		a = 15'($random(seed));
		@(posedge clk);
		sense <= s;
		expq.push_back(s);
		host.cmd(a, 1'b1, 1'b0, 1'b0, 1'b0, 33'h0);
		wait_on(1);
		// start during lock is ignored
		host.cmd(~a, 1'b1, 1'b0, 1'b0, 1'b0, 33'h0);
		repeat (10) tick();
		check("locked", {busy, locked}, 2'b11);
		// split cycle: new data loaded, then restore
		w = 33'({$random(seed), $random(seed)}) & ~33'h1;
		host.cmd(a, 1'b0, 1'b0, 1'b0, 1'b1, w);
		tick();
		check("rdata_load", rdata, w);
		@(posedge clk);
		sense <= ~w;
		host.cmd(a, 1'b0, 1'b1, 1'b0, 1'b0, 33'h0);
		wait_on(2);
		tick();
		e_inh = '0;
		for (int b = 0; b < 33; b++)
			e_inh[b * 8 + {a[14], a[13], a[6]}] = !w[b];
		check("inh", inh, e_inh);
		check("rdata_write", rdata, w);
		wait_on(0);
		// clear in mid-read ends the cycle
		host.cmd(a, 1'b1, 1'b0, 1'b0, 1'b0, 33'h0);
		repeat (3) tick();
		host.cmd(a, 1'b0, 1'b0, 1'b1, 1'b0, 33'h0);
		tick();
		check("clear", {busy, locked, rdata}, 35'h0);
		// clear while locked throws the sensed word away unwritten
		expq.push_back(~w);
		host.cmd(a, 1'b1, 1'b0, 1'b0, 1'b0, 33'h0);
		wait_on(1);
		host.cmd(a, 1'b0, 1'b0, 1'b1, 1'b0, 33'h0);
		tick();
		check("clear_lock", {busy, locked, rdata}, 35'h0);
		finish_test();
	end
endmodule // core_memory_select_control_tb_top
`default_nettype wire
